// file: flash_host_pkg.sv
// package of constants and types for the parallel flash host controller
// Function
// R1: device drives data only when selected and read-enabled; the model drives the inverse of its last read otherwise
// R2: write when write strobe low, select low, output high
// R3: address on later fall, data on earlier rise
// R4: command latch never alters array directly
// R5: deselected device keeps outputs high impedance; the model drives the inverse of its last read instead
// R6: output enable high disables device drivers; the model then drives the inverse of its last read
// R7: id voltage returns id byte per byte select
// R8: id bytes carry odd parity in top bit
// R9: host holds id page select low for id
// R10: long reset pulse aborts and returns to read
// R11: host restarts operation interrupted by reset; code redoes nothing, only answers after recovery
// R12: device powers up in read state
// R13: power-up with write asserted accepts no command
// R14: control glitches under 10 ns start no write
// R15: bad or misordered cycle returns to read mode
// R16: after id entry, address 00 maker, 01 device
// R17: program is four cycles, starts at last rise
// R18: program done when poll bit equals written bit
// R19: commands during program are ignored
// R20: program only clears bits; erase sets them
// R21: chip erase six cycles; done when poll reads one
// R22: sector erase six cycles, sector address last
// R23: unlock 5555/aa, 2aaa/55, then command codes
// R24: poll bit complemented while program, zero while erase
// R25: toggle bit flips on each read while busy
// R26: locked boot sector erase does nothing, returns read
// R27: id voltage is one digital qualifier input
package flash_host_pkg;

  // ****************************************************************
  // widths and command codes
  // ****************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 18'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 18'h02aaa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'haa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECTOR   = 8'h30;
  localparam logic [DATA_W-1:0] CMD_LOCKOUT  = 8'h40;
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [DATA_W-1:0] CMD_ID_EXIT  = 8'hf0;
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  // ****************************************************************
  // timing, clock 25 mhz
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int GLITCH_NS     = 10;
  localparam int SETUP_NS      = 80;  // strobe phase length, beyond glitch
  localparam int RESET_NS      = 500; // restart pulse width
  localparam int RECOVER_NS    = 200; // wait after restart release
  localparam int SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC   = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W       = 8;

  // ****************************************************************
  // user operations and carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_CHIP    = 3'h2,
    OP_SECTOR  = 3'h3,
    OP_LOCKOUT = 3'h4,
    OP_ID_ON   = 3'h5,
    OP_ID_OFF  = 3'h6,
    OP_RESTART = 3'h7
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } pins_t;

endpackage

// file: flash_bus_cycle.sv
// one timed bus cycle (read or write) on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
  input  wire logic                              ref_clk_i,
  input  wire logic                              sys_rst_i,
  input  wire logic                              start_i,
  input  wire logic                              write_i,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0] data_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0] din_sync_i,
  output logic                                   busy_o,
  output logic                                   done_o,
  output logic [flash_host_pkg::DATA_W-1:0]      rdata_o,
  output logic                                   ce_n_o,
  output logic                                   oe_n_o,
  output logic                                   we_n_o,
  output logic [flash_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [flash_host_pkg::DATA_W-1:0]      dout_o,
  output logic                                   doe_o
);
  import flash_host_pkg::*;

  // ****************************************************************
  // cycle phases
  // ****************************************************************
  typedef enum logic [3:0] {
    PH_IDLE   = 4'b0001,
    PH_SETUP  = 4'b0010,
    PH_STROBE = 4'b0100,
    PH_HOLD   = 4'b1000
  } phase_t;

  phase_t            ph_reg;   // current phase
  logic [CNT_W-1:0]  cnt_reg;  // cycles left in phase
  logic              wr_reg;   // cycle is a write

  assign busy_o = (ph_reg != PH_IDLE);

  // phase sequencing; every phase lasts at least SETUP_CYC so no strobe is a glitch
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ph_reg  <= PH_IDLE;
      cnt_reg <= '0;
      wr_reg  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (ph_reg)
        PH_IDLE: begin
          if (start_i) begin
            ph_reg  <= PH_SETUP;
            wr_reg  <= write_i;
            cnt_reg <= CNT_W'(SETUP_CYC);
          end
        end
        PH_SETUP: begin
          if (cnt_reg == '0) begin
            ph_reg  <= PH_STROBE;
            cnt_reg <= CNT_W'(SETUP_CYC); // [R14]
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PH_STROBE: begin
          if (cnt_reg == '0) begin
            ph_reg  <= PH_HOLD;
            cnt_reg <= CNT_W'(SETUP_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PH_HOLD: begin
          if (cnt_reg == '0) begin
            ph_reg <= PH_IDLE;
            done_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: ph_reg <= PH_IDLE;
      endcase
    end
  end

  // pin drive: chip select spans setup..hold, write strobe only in strobe phase
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      doe_o  <= 1'b0;
      addr_o <= '0;
      dout_o <= '0;
    end else begin
      if (ph_reg == PH_IDLE && start_i) begin
        addr_o <= addr_i;
        dout_o <= data_i;
        ce_n_o <= 1'b0;
        doe_o  <= write_i;
      end
      if (ph_reg == PH_SETUP && cnt_reg == '0) begin
        // write with output enable high; read with write strobe high
        we_n_o <= ~wr_reg;  // [R2]
        oe_n_o <= wr_reg;   // [R2]
      end
      if (ph_reg == PH_STROBE && cnt_reg == '0) begin
        // strobe rises before chip select, so write-enable edge latches data
        we_n_o <= 1'b1;     // [R3]
        oe_n_o <= 1'b1;
      end
      if (ph_reg == PH_HOLD && cnt_reg == '0) begin
        ce_n_o <= 1'b1;
        doe_o  <= 1'b0;
      end
    end
  end

  // read data sampled at end of strobe, from already-synchronised pins
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else if (ph_reg == PH_STROBE && cnt_reg == '0 && !wr_reg) begin
      rdata_o <= din_sync_i;  // [R1]
    end
  end

endmodule
`default_nettype wire

// file: flash_host.sv
// host controller that drives a parallel flash through its pins
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input  wire logic                              ref_clk_i,
  input  wire logic                              sys_rst_i,
  input  wire logic                              req_valid_i,
  output logic                                   req_ready_o,
  input  wire flash_host_pkg::req_t              req_i,
  output logic                                   resp_valid_o,
  output logic [flash_host_pkg::DATA_W-1:0]      resp_data_o,
  output logic                                   resp_err_o,
  output flash_host_pkg::pins_t                  pins_o,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output logic                                   id_high_voltage_o
);
  import flash_host_pkg::*;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_IDLE    = 7'b0000001,
    ST_SEQ     = 7'b0000010,
    ST_POLL    = 7'b0000100,
    ST_RESET   = 7'b0001000,
    ST_RECOVER = 7'b0010000,
    ST_ID      = 7'b0100000,
    ST_DONE    = 7'b1000000
  } state_t;

  state_t              st_reg;      // sequencer state
  req_t                req_reg;     // accepted request
  logic [2:0]          idx_reg;     // write cycle index in sequence
  logic [2:0]          len_reg;     // number of write cycles
  logic [CNT_W-1:0]    tmr_reg;     // reset and recovery timer
  logic [DATA_W-1:0]   dq_meta_reg; // first synchroniser stage
  logic [DATA_W-1:0]   dq_sync_reg; // second synchroniser stage
  logic [DATA_W-1:0]   prev_reg;    // previous poll read
  logic                first_reg;   // no previous poll read yet
  logic                id_mode_reg; // id voltage asserted
  logic                cyc_start;   // start one bus cycle
  logic                cyc_write;   // that cycle writes
  logic [ADDR_W-1:0]   cyc_addr;
  logic [DATA_W-1:0]   cyc_data;
  logic                cyc_busy;
  logic                cyc_done;
  logic [DATA_W-1:0]   cyc_rdata;
  logic                bc_ce_n;
  logic                bc_oe_n;
  logic                bc_we_n;
  logic [ADDR_W-1:0]   bc_addr;
  logic [DATA_W-1:0]   bc_dout;
  logic                bc_doe;

  // ****************************************************************
  // data pin synchroniser
  // ****************************************************************
  // device answers asynchronously; two stages before any logic looks
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= dq_i;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ****************************************************************
  // command sequence table
  // ****************************************************************
  // address and data for write cycle idx of the accepted operation
  always_comb begin
    cyc_addr = UNLOCK1_ADDR;                    // [R23]
    cyc_data = UNLOCK1_DATA;
    case (idx_reg)
      3'h0: begin
        cyc_addr = UNLOCK1_ADDR;
        cyc_data = UNLOCK1_DATA;
      end
      3'h1, 3'h4: begin
        cyc_addr = UNLOCK2_ADDR;
        cyc_data = UNLOCK2_DATA;
      end
      3'h2: begin
        cyc_addr = UNLOCK1_ADDR;
        case (req_reg.op)
          OP_PROGRAM: cyc_data = CMD_PROGRAM;   // [R17]
          OP_ID_ON:   cyc_data = CMD_ID_ENTRY;  // [R16]
          OP_ID_OFF:  cyc_data = CMD_ID_EXIT;
          default:    cyc_data = CMD_ERASE;     // [R21]
        endcase
      end
      3'h3: begin
        if (req_reg.op == OP_PROGRAM) begin
          cyc_addr = req_reg.addr;              // [R17]
          cyc_data = req_reg.data;              // [R20]
        end else begin
          cyc_addr = UNLOCK1_ADDR;
          cyc_data = UNLOCK1_DATA;
        end
      end
      3'h5: begin
        case (req_reg.op)
          OP_SECTOR: begin
            cyc_addr = req_reg.addr;            // [R22]
            cyc_data = CMD_SECTOR;
          end
          OP_LOCKOUT: cyc_data = CMD_LOCKOUT;
          default:    cyc_data = CMD_CHIP;      // [R21]
        endcase
      end
      default: begin
        cyc_addr = UNLOCK1_ADDR;
        cyc_data = UNLOCK1_DATA;
      end
    endcase
  end

  // cycle length by operation
  function automatic logic [2:0] seq_len(input op_t op);
    case (op)
      OP_PROGRAM:          seq_len = 3'h4;
      OP_ID_ON, OP_ID_OFF: seq_len = 3'h3;
      default:             seq_len = 3'h6;
    endcase
  endfunction

  // ****************************************************************
  // bus cycle launch
  // ****************************************************************
  assign req_ready_o = (st_reg == ST_IDLE);
  assign cyc_write   = (st_reg == ST_SEQ);
  // one cycle is launched only when the engine is idle and not finishing
  assign cyc_start   = !cyc_busy && !cyc_done &&
                       (st_reg == ST_SEQ || st_reg == ST_POLL || st_reg == ST_ID);

  flash_bus_cycle u_cycle (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (cyc_start),
    .write_i    (cyc_write),
    .addr_i     ((st_reg == ST_SEQ) ? cyc_addr : req_reg.addr),
    .data_i     (cyc_data),
    .din_sync_i (dq_sync_reg),
    .busy_o     (cyc_busy),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .ce_n_o     (bc_ce_n),
    .oe_n_o     (bc_oe_n),
    .we_n_o     (bc_we_n),
    .addr_o     (bc_addr),
    .dout_o     (bc_dout),
    .doe_o      (bc_doe)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // accepts one request, walks its cycles, polls until the device is done
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_reg       <= ST_IDLE;
      req_reg      <= '0;
      idx_reg      <= '0;
      len_reg      <= '0;
      tmr_reg      <= '0;
      prev_reg     <= '0;
      first_reg    <= 1'b1;
      resp_valid_o <= 1'b0;
      resp_data_o  <= '0;
      resp_err_o   <= 1'b0;
    end else begin
      resp_valid_o <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (req_valid_i) begin
            req_reg   <= req_i;
            idx_reg   <= '0;
            len_reg   <= seq_len(req_i.op);
            first_reg <= 1'b1;
            resp_err_o <= 1'b0;
            if (req_i.op == OP_RESTART) begin
              st_reg  <= ST_RESET;               // [R10]
              tmr_reg <= CNT_W'(RESET_CYC);
            end else if (req_i.op == OP_READ) begin
              st_reg <= ST_ID;                   // plain read cycle
            end else begin
              st_reg <= ST_SEQ;
            end
          end
        end
        ST_SEQ: begin
          if (cyc_done) begin
            if (idx_reg == len_reg - 3'h1) begin
              // id commands finish at once; program and erase run embedded
              st_reg <= (req_reg.op == OP_ID_ON || req_reg.op == OP_ID_OFF) ? ST_DONE : ST_POLL;
            end
            idx_reg <= idx_reg + 3'h1;
          end
        end
        ST_POLL: begin
          // nothing else is written while the device is busy
          if (cyc_done) begin                    // [R19]
            first_reg <= 1'b0;
            prev_reg  <= cyc_rdata;
            // busy while toggle bit flips between reads
            if (!first_reg && (cyc_rdata[TOGGLE_BIT] == prev_reg[TOGGLE_BIT])) begin // [R25]
              if (req_reg.op == OP_PROGRAM) begin
                // toggle bit has stopped; error unless the whole read byte equals the written data
                resp_err_o <= (cyc_rdata != req_reg.data); // [R18] [R24]
              end else begin
                // erase ends with poll bit one; a locked boot sector stays put
                resp_err_o <= !cyc_rdata[POLL_BIT]; // [R21] [R26]
              end
              resp_data_o <= cyc_rdata;
              st_reg      <= ST_DONE;
            end
          end
        end
        ST_ID: begin
          if (cyc_done) begin
            resp_data_o <= cyc_rdata;            // [R7] [R8]
            st_reg      <= ST_DONE;
          end
        end
        ST_RESET: begin
          // hold restart long enough; any interrupted work must be redone
          if (tmr_reg == '0) begin
            st_reg  <= ST_RECOVER;
            tmr_reg <= CNT_W'(RECOVER_CYC);
          end else begin
            tmr_reg <= tmr_reg - 1'b1;           // [R10]
          end
        end
        ST_RECOVER: begin
          if (tmr_reg == '0) begin
            st_reg <= ST_DONE;                   // [R11]
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        ST_DONE: begin
          resp_valid_o <= 1'b1;
          st_reg       <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // id voltage qualifier follows the id byte-read requests only
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      id_mode_reg <= 1'b0;
    end else if (st_reg == ST_IDLE && req_valid_i) begin
      id_mode_reg <= (req_i.op == OP_READ) && req_i.data[0]; // [R27]
    end
  end

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  always_comb begin
    pins_o.ce_n  = bc_ce_n;
    pins_o.oe_n  = bc_oe_n;
    pins_o.we_n  = bc_we_n;
    pins_o.rst_n = (st_reg != ST_RESET);          // [R10]
    pins_o.addr  = bc_addr;
    if (id_mode_reg) begin
      pins_o.addr[1] = 1'b0;                      // [R9]
    end
    pins_o.dout  = bc_dout;
    pins_o.doe   = bc_doe && bc_oe_n;             // never fight the device [R6]
  end
  assign id_high_voltage_o = id_mode_reg;

endmodule
`default_nettype wire

// file: flash_host_sva.sv
// pin-level checker for the parallel flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_sva (
  input wire logic                  ref_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  req_ready_o,
  input wire logic                  resp_valid_o,
  input wire flash_host_pkg::pins_t pins_o,
  input wire logic                  id_high_voltage_o
);
  import flash_host_pkg::*;
  // ****************************************************************
  // helper logic and assertions
  // ****************************************************************
  logic [CNT_W-1:0] low_cnt_reg; // restart low cycles, saturating
  // a counter, since a long repetition would be unrolled
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || pins_o.rst_n) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_pins_idle: assert property ($fell(sys_rst_i) |-> pins_o.ce_n && pins_o.oe_n && pins_o.we_n
    && !pins_o.doe && req_ready_o) else $error("pins not idle");
  a_write_inhibit_ok: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n && pins_o.doe)
    else $error("bad write strobe");
  a_read_no_drive: assert property (!pins_o.oe_n |-> !pins_o.doe && pins_o.we_n && !pins_o.ce_n)
    else $error("drive during read");
  a_write_pulse_len: assert property ($fell(pins_o.we_n) |=> !pins_o.we_n [*2])
    else $error("write strobe too short");
  a_read_pulse_len: assert property ($fell(pins_o.oe_n) |=> !pins_o.oe_n [*2])
    else $error("read strobe too short");
  a_strobe_addr_stable: assert property (!pins_o.we_n && $past(!pins_o.we_n) |-> $stable(pins_o.addr)
    && $stable(pins_o.dout)) else $error("bus moved under strobe");
  a_data_at_rise: assert property ($rose(pins_o.we_n) |-> !pins_o.ce_n && pins_o.doe)
    else $error("data gone at strobe rise");
  a_restart_width: assert property ($rose(pins_o.rst_n) |-> low_cnt_reg >= RESET_CYC)
    else $error("restart pulse too short");
  a_restart_quiet: assert property (!pins_o.rst_n |-> pins_o.we_n && pins_o.oe_n)
    else $error("strobe in restart");
  a_id_page_low: assert property (id_high_voltage_o && !pins_o.ce_n |-> !pins_o.addr[1])
    else $error("page select high");
  a_resp_one_pulse: assert property (resp_valid_o |=> !resp_valid_o && req_ready_o)
    else $error("response not one pulse");
endmodule
bind flash_host flash_host_sva u_sva (.*);
`default_nettype wire

// file: flash_model.sv
// behavioural model of the parallel flash device seen by the host
`timescale 1ns/1ps
`default_nettype none
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h31, // arbitrary value, odd parity
  parameter logic [7:0] PART_CODE  = 8'h8c  // arbitrary value, odd parity
) (
  input  wire flash_host_pkg::pins_t             pins_i,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  input  wire logic                              id_hv_i,
  output logic [flash_host_pkg::DATA_W-1:0]      dq_o
);
  // ****************************************************************
  // array, command state and read path
  // ****************************************************************
  logic [7:0]        mem [0:(1<<ADDR_W)-1]; // whole array, erased at start
  logic [7:0]        rd_q, wr_d;             // last read value, last programmed byte
  logic [ADDR_W-1:0] wr_a;                   // address latched on strobe fall
  logic              id_mode, locked, erasing, tog, armed;
  int                step = 0;               // position in the unlock sequence
  realtime           busy_end = 0, t_fall = 0;
  wire sel = !pins_i.ce_n && pins_i.rst_n;
  // released bus shows the inverse, so stale data never passes
  assign dq_o = (sel && !pins_i.oe_n) ? rd_q : ~rd_q;
  function automatic logic busy();
    return $realtime < busy_end;
  endfunction
  // sector index from the block boundaries
  function automatic int sec_of(input logic [ADDR_W-1:0] a);
    return (a >= 18'h3c000) + (a >= 18'h3a000) + (a >= 18'h38000) + (a >= 18'h20000);
  endfunction
  initial begin
    for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hff;
    {id_mode, locked, erasing, tog, armed, rd_q, wr_d, wr_a} = '0; // powers up in read state
  end
  // read strobe: status while busy, id codes, else array
  always @(negedge pins_i.oe_n) begin
    if (sel && pins_i.we_n) begin
      if (busy()) begin
        rd_q = {erasing ? 1'b0 : ~wr_d[7], tog, 6'h00};
        tog = ~tog;
      end else if (id_hv_i) rd_q = pins_i.addr[1] ? 8'h00 : (pins_i.addr[0] ? PART_CODE : MAKER_CODE);
      else if (id_mode && pins_i.addr[7:1] == 7'h00) rd_q = pins_i.addr[0] ? PART_CODE : MAKER_CODE;
      else rd_q = mem[pins_i.addr];
    end
  end
  // write strobe: a strobe low since power-up is never taken
  always @(negedge pins_i.we_n) begin
    t_fall = $realtime;
    armed = 1'b1;
    if (!pins_i.ce_n) wr_a = pins_i.addr;
  end
  always @(posedge pins_i.we_n) begin
    if (armed && sel && pins_i.oe_n && $realtime - t_fall >= GLITCH_NS) command(wr_a, dq_i);
  end
  // restart pin aborts everything
  always @(negedge pins_i.rst_n) begin
    busy_end = 0;
    step = 0;
    id_mode = 1'b0;
  end
  task automatic command(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = a[14:0] == 15'h5555;
    u2 = a[14:0] == 15'h2aaa;
    if (busy()) return;
    if (d == CMD_ID_EXIT && step != 3) begin
      id_mode = 1'b0;
      step = 0;
      return;
    end
    case (step) // the latch never touches the array directly
      0, 4: step = (u1 && d == UNLOCK1_DATA) ? step + 1 : 0;
      1, 5: step = (u2 && d == UNLOCK2_DATA) ? step + 1 : 0;
      2: begin
        step = (u1 && d == CMD_PROGRAM) ? 3 : (u1 && d == CMD_ERASE) ? 4 : 0;
        if (u1 && d == CMD_ID_ENTRY) id_mode = 1'b1;
      end
      3: begin
        mem[a] = mem[a] & d;
        wr_d = d;
        erasing = 1'b0;
        busy_end = $realtime + 2000.0;
        step = 0;
      end
      6: begin
        erasing = 1'b1;
        if (u1 && d == CMD_CHIP) begin
          for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hff;
          busy_end = $realtime + 6000.0;
        end else if (d == CMD_SECTOR && locked && a >= 18'h3c000) busy_end = $realtime + 100.0;
        else if (d == CMD_SECTOR) begin
          for (int i = 0; i < (1<<ADDR_W); i++) if (sec_of(ADDR_W'(i)) == sec_of(a)) mem[i] = 8'hff;
          busy_end = $realtime + 4000.0;
        end else if (u1 && d == CMD_LOCKOUT) locked = 1'b1;
        step = 0;
      end
      default: step = 0;
    endcase
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking testbench of the flash host against the device model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_host_pkg::*;
  // ****************************************************************
  // wiring, clock and shared tasks
  // ****************************************************************
  localparam logic [7:0] MAKER = 8'h31; // arbitrary identity values
  localparam logic [7:0] PART  = 8'h8c;
  logic       ref_clk_i, sys_rst_i, req_valid_i, req_ready_o, resp_valid_o, resp_err_o, id_high_voltage_o;
  req_t       req_i;
  pins_t      pins_o;
  logic [7:0] resp_data_o, dq_i, dev_q;
  int         bad_count, total_checks;
  // shared data bus: host wins while it drives
  assign dq_i = pins_o.doe ? pins_o.dout : dev_q;
  flash_host dut (.*);
  flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) model (.pins_i(pins_o), .dq_i(dq_i),
    .id_hv_i(id_high_voltage_o), .dq_o(dev_q));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request, then a bounded wait for completion
  task do_req(input op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{op, a, d};
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    #1;
    n = 0;
    while (resp_valid_o !== 1'b1 && n < 4000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(n < 4000, 1);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    do_req(OP_READ, a, 8'h00);
    check(resp_data_o, exp);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_program;
    rd(18'h00100, 8'hff);
    do_req(OP_PROGRAM, 18'h00100, 8'h5a);
    check(resp_err_o, 1'b0);
    rd(18'h00100, 8'h5a);
    do_req(OP_PROGRAM, 18'h00100, 8'ha5); // a cleared bit cannot come back
    check(resp_err_o, 1'b1);
    rd(18'h00100, 8'h00);
  endtask
  task t_id_cmd;
    do_req(OP_ID_ON, 18'h00000, 8'h00);
    rd(18'h00000, MAKER);
    rd(18'h00001, PART);
    check(^resp_data_o, 1'b1);
    do_req(OP_ID_OFF, 18'h00000, 8'h00);
    rd(18'h00100, 8'h00);
  endtask
  task t_id_volt;
    do_req(OP_READ, 18'h00002, 8'h01); // page select must be pulled low
    check(resp_data_o, MAKER);
    do_req(OP_READ, 18'h12303, 8'h01);
    check(resp_data_o, PART);
  endtask
  task t_erase;
    do_req(OP_PROGRAM, 18'h20010, 8'h11);
    do_req(OP_PROGRAM, 18'h3c010, 8'h00);
    do_req(OP_SECTOR, 18'h00155, 8'h00);
    check(resp_err_o, 1'b0);
    rd(18'h00100, 8'hff);
    rd(18'h20010, 8'h11);
    do_req(OP_LOCKOUT, 18'h05555, 8'h00);
    do_req(OP_SECTOR, 18'h3c000, 8'h00);
    rd(18'h3c010, 8'h00);
    do_req(OP_CHIP, 18'h05555, 8'h00);
    check(resp_err_o, 1'b0);
    rd(18'h20010, 8'hff);
    rd(18'h3c010, 8'hff);
  endtask
  task t_restart;
    do_req(OP_ID_ON, 18'h00000, 8'h00);
    do_req(OP_RESTART, 18'h00000, 8'h00); // pulse drops id mode
    rd(18'h00000, 8'hff);
  endtask
  // watchdog: the run needs far fewer cycles
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    sys_rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_program();
    t_id_cmd();
    t_id_volt();
    t_erase();
    t_restart();
    finish_test();
  end
endmodule
`default_nettype wire
